// ===== design/descriptor_list_dma.sv
// Descriptor-list DMA engine moving frames between host memory and the FIFOs
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "descriptor_list_dma_consts.svh"
module descriptor_list_dma
  import descriptor_list_dma_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_byte,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  input  wire logic        rx_error,
  output logic             rx_ready,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready
);
  import descriptor_list_dma_pkg::*;

  dma_state_t            state_r, state_nxt;
  logic [31:0]           desc_r, desc_nxt, link_r, link_nxt, cstat_r, cstat_nxt;
  logic [31:0]           fbase_r, fbase_nxt, flen_r, flen_nxt, faddr_r, faddr_nxt;
  logic [`ENTRY_W-1:0]   entry_r, entry_nxt;
  logic [`COUNT_W-1:0]   fcnt_r, fcnt_nxt, len_r, len_nxt;
  logic [7:0]            byte_r, byte_nxt;
  logic                  tx_dir_r, tx_dir_nxt, ovf_r, ovf_nxt, last_r, last_nxt;
  logic                  impl_r, impl_nxt, err_r, err_nxt;
  logic [31:0]           tx_ptr, rx_ptr, state_word, ent_off;
  logic                  rx_en, tx_en, rx_end, tx_end, rx_adv, tx_adv;

  // ==========================================
  // Register file
  dma_apb_regs u_regs (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .rx_adv          (rx_adv),
    .tx_adv          (tx_adv),
    .next_link       (link_r),
    .state_word      (state_word),
    .busy            (state_r != S_IDLE),
    .tx_list_pointer (tx_ptr),
    .rx_list_pointer (rx_ptr),
    .rx_en           (rx_en),
    .tx_en           (tx_en),
    .rx_chain_end    (rx_end),
    .tx_chain_end    (tx_end)
  );

  // ==========================================
  // Memory request
  assign ent_off = {22'h00_0000, entry_r, 3'h0};
  always_comb begin
    state_word = cstat_r & ~(32'h0000_0001 << `OVERFLOW_BIT);
    state_word[`COUNT_W-1:0]    = len_r;
    state_word[`DONE_BIT]       = 1'b1;
    state_word[`FRAME_ERR_BIT]  = err_r;
    state_word[`SHORT_BIT]      = len_r < `SHORT_LIMIT;
    state_word[`OVERFLOW_BIT]   = ovf_r;
    state_word[`IMPLIED_BIT]    = impl_r;
  end

  always_comb begin
    mem_req   = 1'b1;
    mem_we    = 1'b0;
    mem_byte  = 1'b0;
    mem_addr  = desc_r;
    mem_wdata = `RESET_WORD;
    unique case (state_r)
      S_LINK_RD:  mem_addr = desc_r + `DESC_LINK_OFF;
      S_STAT_RD:  mem_addr = desc_r + `DESC_STAT_OFF;
      S_FADDR_RD: mem_addr = desc_r + `FRAG_BASE_OFF + ent_off;
      S_FLEN_RD:  mem_addr = desc_r + `FRAG_SIZE_OFF + ent_off;
      S_BWR: begin
        mem_we    = 1'b1;
        mem_byte  = 1'b1;
        mem_addr  = fbase_r;
        mem_wdata = {24'h00_0000, byte_r};
      end
      S_BRD: begin
        mem_byte = 1'b1;
        mem_addr = fbase_r;
      end
      S_FLAST_WR: begin
        mem_we    = 1'b1;
        mem_addr  = faddr_r;
        mem_wdata = flen_r | (32'h0000_0001 << `FINAL_FRAG_BIT);
      end
      S_STAT_WR: begin
        mem_we    = 1'b1;
        mem_addr  = desc_r + `DESC_STAT_OFF;
        mem_wdata = tx_dir_r ? (cstat_r | (32'h0000_0001 << `DONE_BIT)) : state_word;
      end
      default:    mem_req = 1'b0;
    endcase
  end

  // ==========================================
  // Sequencer
  always_comb begin
    state_nxt  = state_r;
    desc_nxt   = desc_r;
    link_nxt   = link_r;
    cstat_nxt  = cstat_r;
    fbase_nxt  = fbase_r;
    flen_nxt   = flen_r;
    faddr_nxt  = faddr_r;
    entry_nxt  = entry_r;
    fcnt_nxt   = fcnt_r;
    len_nxt    = len_r;
    byte_nxt   = byte_r;
    tx_dir_nxt = tx_dir_r;
    ovf_nxt    = ovf_r;
    last_nxt   = last_r;
    impl_nxt   = impl_r;
    err_nxt    = err_r;
    rx_ready   = 1'b0;
    rx_adv     = 1'b0;
    tx_adv     = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        if (rx_en && !rx_end && rx_valid) begin
          tx_dir_nxt = 1'b0;
          desc_nxt   = {rx_ptr[31:`DESC_ALIGN_BITS], 3'h0};
          state_nxt  = S_LINK_RD;
        end else if (tx_en && !tx_end) begin
          tx_dir_nxt = 1'b1;
          desc_nxt   = tx_ptr;
          state_nxt  = S_LINK_RD;
        end
      end
      S_LINK_RD: if (mem_ack) begin
        link_nxt  = mem_rdata;
        state_nxt = S_STAT_RD;
      end
      S_STAT_RD: if (mem_ack) begin
        cstat_nxt = mem_rdata;
        entry_nxt = '0;
        len_nxt   = '0;
        ovf_nxt   = 1'b0;
        err_nxt   = 1'b0;
        impl_nxt  = !tx_dir_r && mem_rdata[`IMPLIED_BIT];
        fbase_nxt = desc_r + `IMPLIED_DATA_OFF;
        state_nxt = (!tx_dir_r && mem_rdata[`IMPLIED_BIT]) ? S_FLEN_RD : S_FADDR_RD;
      end
      S_FADDR_RD: if (mem_ack) begin
        fbase_nxt = mem_rdata;
        state_nxt = S_FLEN_RD;
      end
      S_FLEN_RD: if (mem_ack) begin
        flen_nxt  = mem_rdata;
        faddr_nxt = mem_addr;
        fcnt_nxt  = mem_rdata[`COUNT_W-1:0];
        if (mem_rdata[`COUNT_W-1:0] == '0) begin
          state_nxt = tx_dir_r ? S_STAT_WR : S_DRAIN;
        end else begin
          state_nxt = S_DATA;
        end
      end
      S_DATA: begin
        if (fcnt_r == '0) begin
          entry_nxt = entry_r + 7'h01;
          if (tx_dir_r && flen_r[`FINAL_FRAG_BIT]) begin
            state_nxt = S_STAT_WR;
          end else if (impl_r || entry_r == `LAST_ENTRY) begin
            state_nxt = tx_dir_r ? S_STAT_WR : S_DRAIN;
          end else begin
            state_nxt = S_FADDR_RD;
          end
        end else if (tx_dir_r) begin
          state_nxt = S_BRD;
        end else if (rx_valid) begin
          rx_ready  = 1'b1;
          byte_nxt  = rx_data;
          last_nxt  = rx_last;
          err_nxt   = err_r | rx_error;
          len_nxt   = len_r + 13'h0001;
          state_nxt = S_BWR;
        end
      end
      S_BWR: if (mem_ack) begin
        fbase_nxt = fbase_r + 32'h0000_0001;
        fcnt_nxt  = fcnt_r - 13'h0001;
        state_nxt = last_r ? S_FLAST_WR : S_DATA;
      end
      S_BRD: if (mem_ack) begin
        byte_nxt  = mem_rdata[7:0];
        state_nxt = S_TXO;
      end
      S_TXO: if (tx_ready) begin
        fbase_nxt = fbase_r + 32'h0000_0001;
        fcnt_nxt  = fcnt_r - 13'h0001;
        state_nxt = S_DATA;
      end
      S_DRAIN: begin
        ovf_nxt  = 1'b1;
        rx_ready = 1'b1;
        if (rx_valid) begin
          len_nxt = len_r + 13'h0001;
          err_nxt = err_r | rx_error;
          if (rx_last) begin
            state_nxt = S_FLAST_WR;
          end
        end
      end
      S_FLAST_WR: if (mem_ack) begin
        state_nxt = S_STAT_WR;
      end
      S_STAT_WR: if (mem_ack) begin
        state_nxt = S_NEXT;
      end
      S_NEXT: begin
        // link followed; zero link stops the chain
        rx_adv    = !tx_dir_r;
        tx_adv    = tx_dir_r;
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= S_IDLE;
      desc_r   <= `RESET_WORD;
      link_r   <= `RESET_WORD;
      cstat_r  <= `RESET_WORD;
      fbase_r  <= `RESET_WORD;
      flen_r   <= `RESET_WORD;
      faddr_r  <= `RESET_WORD;
      entry_r  <= '0;
      fcnt_r   <= '0;
      len_r    <= '0;
      byte_r   <= 8'h00;
      tx_dir_r <= 1'b0;
      ovf_r    <= 1'b0;
      last_r   <= 1'b0;
      impl_r   <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      desc_r   <= desc_nxt;
      link_r   <= link_nxt;
      cstat_r  <= cstat_nxt;
      fbase_r  <= fbase_nxt;
      flen_r   <= flen_nxt;
      faddr_r  <= faddr_nxt;
      entry_r  <= entry_nxt;
      fcnt_r   <= fcnt_nxt;
      len_r    <= len_nxt;
      byte_r   <= byte_nxt;
      tx_dir_r <= tx_dir_nxt;
      ovf_r    <= ovf_nxt;
      last_r   <= last_nxt;
      impl_r   <= impl_nxt;
      err_r    <= err_nxt;
    end
  end

  assign tx_data  = byte_r;
  assign tx_valid = state_r == S_TXO;
  assign tx_last  = tx_valid && fcnt_r == 13'h0001 && flen_r[`FINAL_FRAG_BIT];

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FRAG_BASE_OFF: assert property (
    state_r == S_FADDR_RD |-> mem_addr == desc_r + 32'h8 + {22'h0, entry_r, 3'h0})
    else $error("fragment base offset wrong");
  AST_FRAG_SIZE_OFF: assert property (
    state_r == S_FLEN_RD |-> mem_addr == desc_r + 32'hC + {22'h0, entry_r, 3'h0})
    else $error("fragment size offset wrong");
  AST_FINAL_MARK: assert property (
    state_r == S_BWR && mem_ack && last_r |=> mem_we && mem_wdata[31] && mem_addr == faddr_r)
    else $error("final fragment not marked");
  AST_DONE_BIT: assert property (
    state_r == S_STAT_WR |-> mem_we && mem_wdata[15] && mem_addr == desc_r + 32'h4)
    else $error("done bit missing");
  AST_SHORT: assert property (
    state_r == S_STAT_WR && !tx_dir_r |-> mem_wdata[17] == (len_r < 13'h03C))
    else $error("short flag wrong");
  AST_OVERFLOW: assert property (
    state_r == S_DRAIN && rx_valid && rx_last
    |-> ##[1:20] (state_r == S_STAT_WR && mem_wdata[20]))
    else $error("overflow flag missing");
  AST_CHAIN_STOP: assert property (
    rx_adv && link_r == 32'h0 |=> rx_end ##1 (state_r != S_LINK_RD || tx_dir_r))
    else $error("chain followed past zero link");
  AST_ANY_BYTE: assert property (
    state_r == S_BWR |-> mem_byte && mem_addr == fbase_r && mem_wdata[7:0] == byte_r)
    else $error("fragment byte address wrong");
  AST_RX_START: assert property (
    state_r == S_IDLE && rx_en && !rx_end && rx_valid
    |=> state_r == S_LINK_RD && desc_r == {$past(rx_ptr[31:3]), 3'h0})
    else $error("receive descriptor not from list pointer");
  AST_IMPLIED: assert property (
    state_r == S_STAT_RD && mem_ack && !tx_dir_r && mem_rdata[28] |=> state_r == S_FLEN_RD)
    else $error("implied layout not taken");
  AST_REQ_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped");

  COV_RX_FRAME: cover property (state_r == S_NEXT && !tx_dir_r && !ovf_r);
  COV_RX_OVF:   cover property (state_r == S_NEXT && !tx_dir_r && ovf_r);
  COV_TX_FRAME: cover property (state_r == S_NEXT && tx_dir_r);
  COV_IMPLIED:  cover property (state_r == S_STAT_WR && impl_r);
endmodule

// ===== design/descriptor_list_dma_consts.svh
// Offsets, field positions and reset values of the descriptor-list DMA
`ifndef DESCRIPTOR_LIST_DMA_CONSTS_SVH
`define DESCRIPTOR_LIST_DMA_CONSTS_SVH
// ==========================================
// Descriptor layout
`define DESC_LINK_OFF    32'h0000_0000
`define DESC_STAT_OFF    32'h0000_0004
`define FRAG_BASE_OFF    32'h0000_0008
`define FRAG_SIZE_OFF    32'h0000_000C
`define FRAG_STEP_SHIFT  3
`define IMPLIED_DATA_OFF 32'h0000_0010
`define LAST_ENTRY       7'h3F
`define ENTRY_W          7
`define DESC_ALIGN_BITS  3
// ==========================================
// Word fields
`define COUNT_W          13
`define FINAL_FRAG_BIT   31
`define DONE_BIT         15
`define FRAME_ERR_BIT    14
`define SHORT_BIT        17
`define OVERFLOW_BIT     20
`define IMPLIED_BIT      28
`define SHORT_LIMIT      13'h003C
// ==========================================
// Register map
`define REG_TX_PTR       12'h000
`define REG_RX_PTR       12'h004
`define REG_CTRL         12'h008
`define REG_STATUS       12'h00C
`define REG_LAST_STATE   12'h010
`define CTRL_RX_EN_BIT   0
`define CTRL_TX_EN_BIT   1
`define ST_BUSY_BIT      0
`define ST_RX_END_BIT    1
`define ST_TX_END_BIT    2
`define RESET_WORD       32'h0000_0000
`endif

// ===== design/descriptor_list_dma_pkg.sv
// Types shared by the descriptor-list DMA files
package descriptor_list_dma_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_LINK_RD, S_STAT_RD, S_FADDR_RD, S_FLEN_RD, S_DATA, S_BWR,
    S_BRD, S_TXO, S_DRAIN, S_FLAST_WR, S_STAT_WR, S_NEXT
  } dma_state_t;
endpackage

// ===== design/dma_apb_regs.sv
// APB register file of the descriptor-list DMA
`timescale 1ns/1ps
`include "descriptor_list_dma_consts.svh"
module dma_apb_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_adv,
  input  wire logic        tx_adv,
  input  wire logic [31:0] next_link,
  input  wire logic [31:0] state_word,
  input  wire logic        busy,
  output logic      [31:0] tx_list_pointer,
  output logic      [31:0] rx_list_pointer,
  output logic             rx_en,
  output logic             tx_en,
  output logic             rx_chain_end,
  output logic             tx_chain_end
);
  logic [31:0] tx_ptr_r, tx_ptr_nxt, rx_ptr_r, rx_ptr_nxt, last_r, last_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic        rx_end_r, rx_end_nxt, tx_end_r, tx_end_nxt, err_r, err_nxt;
  logic        wr, setup, mapped;

  assign wr     = psel && penable && pwrite;
  assign setup  = psel && !penable;
  assign mapped = (paddr == `REG_TX_PTR) || (paddr == `REG_RX_PTR) ||
                  (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                  (paddr == `REG_LAST_STATE);

  always_comb begin
    tx_ptr_nxt = tx_adv ? next_link : tx_ptr_r;
    rx_ptr_nxt = rx_adv ? next_link : rx_ptr_r;
    last_nxt   = rx_adv ? state_word : last_r;
    ctrl_nxt   = ctrl_r;
    // Set wins over the clear by a pointer write
    rx_end_nxt = rx_end_r;
    tx_end_nxt = tx_end_r;
    if (wr && paddr == `REG_TX_PTR) begin
      tx_ptr_nxt = pwdata;
      tx_end_nxt = 1'b0;
    end
    if (wr && paddr == `REG_RX_PTR) begin
      rx_ptr_nxt = pwdata;
      rx_end_nxt = 1'b0;
    end
    if (wr && paddr == `REG_CTRL) begin
      ctrl_nxt = pwdata[1:0];
    end
    if (rx_adv && next_link == 32'h0000_0000) begin
      rx_end_nxt = 1'b1;
    end
    if (tx_adv && next_link == 32'h0000_0000) begin
      tx_end_nxt = 1'b1;
    end
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup) begin
      err_nxt = !mapped;
      unique case (paddr)
        `REG_TX_PTR:     rdata_nxt = tx_ptr_r;
        `REG_RX_PTR:     rdata_nxt = rx_ptr_r;
        `REG_CTRL:       rdata_nxt = {30'h0000_0000, ctrl_r};
        `REG_STATUS:     rdata_nxt = {29'h0000_0000, tx_end_r, rx_end_r, busy};
        `REG_LAST_STATE: rdata_nxt = last_r;
        default:         rdata_nxt = `RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ptr_r <= `RESET_WORD;
      rx_ptr_r <= `RESET_WORD;
      last_r   <= `RESET_WORD;
      rdata_r  <= `RESET_WORD;
      ctrl_r   <= 2'h0;
      rx_end_r <= 1'b0;
      tx_end_r <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      tx_ptr_r <= tx_ptr_nxt;
      rx_ptr_r <= rx_ptr_nxt;
      last_r   <= last_nxt;
      rdata_r  <= rdata_nxt;
      ctrl_r   <= ctrl_nxt;
      rx_end_r <= rx_end_nxt;
      tx_end_r <= tx_end_nxt;
      err_r    <= err_nxt;
    end
  end

  assign prdata          = rdata_r;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && err_r;
  assign tx_list_pointer = tx_ptr_r;
  assign rx_list_pointer = rx_ptr_r;
  assign rx_en           = ctrl_r[`CTRL_RX_EN_BIT];
  assign tx_en           = ctrl_r[`CTRL_TX_EN_BIT];
  assign rx_chain_end    = rx_end_r;
  assign tx_chain_end    = tx_end_r;
endmodule

// ===== dv/host_mem_model.sv
// Host memory model answering the DMA's bus-master requests
`timescale 1ns/1ps
module host_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_byte,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack,
  input  wire logic        slow
);
  logic [7:0]  bytes_m [0:4095];
  logic [3:0]  wait_r;
  logic [11:0] a;
  assign a = mem_addr[11:0];
  // ==========================================
  // One request at a time, prompt or slow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      wait_r    <= 4'h0;
      mem_rdata <= 32'h5A5A_5A5A;
    end else begin
      mem_ack   <= 1'b0;
      // Idle bus toggles, never holds old data
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_r < (slow ? 4'h6 : 4'h0)) begin
          wait_r <= wait_r + 4'h1;
        end else begin
          wait_r  <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_we && mem_byte) begin
            bytes_m[a] <= mem_wdata[7:0];
          end else if (mem_we) begin
            for (int i = 0; i < 4; i++) begin
              bytes_m[a + 12'(i)] <= mem_wdata[8*i +: 8];
            end
          end else if (mem_byte) begin
            mem_rdata <= {~mem_rdata[31:8], bytes_m[a]};
          end else begin
            mem_rdata <= {bytes_m[a+12'h3], bytes_m[a+12'h2], bytes_m[a+12'h1], bytes_m[a]};
          end
        end
      end
    end
  end
endmodule

// ===== dv/tb.sv
// Self-checking bench of the descriptor-list DMA
`timescale 1ns/1ps
`include "descriptor_list_dma_consts.svh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
  logic        mem_req, mem_we, mem_byte, mem_ack, rx_valid, rx_last, rx_error, rx_ready;
  logic        tx_valid, tx_last, tx_ready;
  logic [7:0]  rx_data, tx_data;
  int          n_mismatch, samples_checked;

  descriptor_list_dma uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .rx_data, .rx_valid, .rx_last, .rx_error, .rx_ready, .tx_data,
    .tx_valid, .tx_last, .tx_ready);
  host_mem_model host (.pclk, .presetn, .mem_req, .mem_we, .mem_byte, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .slow);

  always #50 pclk = ~pclk;

  // ==========================================
  // Reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic timeout_hit();
    n_mismatch++;
    $display("wait bound ran out t=%0t", $time);
    tally_and_finish();
  endtask
  // ==========================================
  // APB master and helpers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 20) timeout_hit();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask
  task automatic put_w(input logic [11:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) host.bytes_m[a + 12'(i)] = d[8*i +: 8];
  endtask
  function automatic logic [31:0] get_w(input logic [11:0] a);
    return {host.bytes_m[a+12'h3], host.bytes_m[a+12'h2], host.bytes_m[a+12'h1], host.bytes_m[a]};
  endfunction
  task automatic build(input logic [11:0] d, input logic [31:0] link, st, base, size);
    put_w(d, link); put_w(d + 12'h4, st); put_w(d + 12'h8, base); put_w(d + 12'hC, size);
  endtask
  task automatic wait_idle();
    logic [31:0] r;
    logic        e;
    int          k;
    k = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0, r, e);
      k++;
      if (k > 100) timeout_hit();
    end while (r[0] !== 1'b0);
  endtask
  task automatic send_frame(input int n, input logic [7:0] first, input logic err);
    logic hs;
    int   k;
    for (int i = 0; i < n; i++) begin
      rx_data <= first + 8'(i); rx_valid <= 1'b1;
      rx_last <= (i == n - 1); rx_error <= err && (i == n - 1);
      k = 0;
      do begin
        @(negedge pclk);
        hs = rx_ready;
        @(posedge pclk);
        k++;
        if (k > 100) timeout_hit();
      end while (hs !== 1'b1);
    end
    rx_valid <= 1'b0; rx_last <= 1'b0; rx_error <= 1'b0; rx_data <= ~rx_data;
  endtask
  // ==========================================
  // Scenarios
  task automatic test_regs();
    for (int i = 0; i < 5; i++) reg_chk(12'(4*i), 32'h0, 1'b0);
    reg_wr(`REG_TX_PTR, 32'h0000_0AB8);
    reg_chk(`REG_TX_PTR, 32'h0000_0AB8, 1'b0);
    reg_wr(`REG_STATUS, 32'hFFFF_FFFF);
    reg_chk(`REG_STATUS, 32'h0, 1'b0);
    reg_chk(12'h020, 32'h0, 1'b1);
    $display("test regs done");
  endtask
  task automatic test_rx_chain();
    build(12'h100, 32'h180, 32'h0, 32'h201, 32'h3);
    put_w(12'h110, 32'h301); put_w(12'h114, 32'hA);
    build(12'h180, 32'h0, 32'h1000_0000, 32'h0, 32'h40);
    reg_wr(`REG_RX_PTR, 32'h100);
    reg_wr(`REG_CTRL, 32'h1);
    slow = 1'b1;
    send_frame(8, 8'h10, 1'b0);
    wait_idle();
    for (int i = 0; i < 3; i++) chk(host.bytes_m[12'h201 + 12'(i)], 8'h10 + 8'(i));
    for (int i = 0; i < 5; i++) chk(host.bytes_m[12'h301 + 12'(i)], 8'h13 + 8'(i));
    chk(host.bytes_m[12'h204], 8'h0);
    chk(get_w(12'h10C), 32'h3);
    chk(get_w(12'h114), 32'h8000_000A);
    chk(get_w(12'h104), 32'h0002_8008);
    reg_chk(`REG_RX_PTR, 32'h180, 1'b0);
    slow = 1'b0;
    send_frame(60, 8'h40, 1'b0);
    wait_idle();
    for (int i = 0; i < 60; i++) chk(host.bytes_m[12'h190 + 12'(i)], 8'h40 + 8'(i));
    chk(host.bytes_m[12'h1CC], 8'h0);
    chk(get_w(12'h184), 32'h1000_803C);
    chk(get_w(12'h18C), 32'h8000_0040);
    reg_chk(`REG_STATUS, 32'h2, 1'b0);
    $display("test rx_chain done");
  endtask
  task automatic test_rx_stop();
    logic hs;
    logic rq;
    rx_valid <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge pclk);
      hs = rx_ready;
      rq = mem_req;
      chk({31'h0, hs}, 32'h0);
      chk({31'h0, rq}, 32'h0);
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    $display("test rx_stop done");
  endtask
  task automatic test_overflow();
    build(12'h400, 32'h0, 32'h0, 32'h480, 32'h4);
    reg_wr(`REG_RX_PTR, 32'h400);
    reg_chk(`REG_STATUS, 32'h0, 1'b0);
    slow = 1'b1;
    send_frame(6, 8'hA0, 1'b1);
    wait_idle();
    for (int i = 0; i < 4; i++) chk(host.bytes_m[12'h480 + 12'(i)], 8'hA0 + 8'(i));
    chk(host.bytes_m[12'h484], 8'h0);
    chk(get_w(12'h404), 32'h0012_C006);
    reg_chk(`REG_LAST_STATE, 32'h0012_C006, 1'b0);
    $display("test overflow done");
  endtask
  task automatic test_tx();
    logic       v, ll;
    logic [7:0] dd;
    int         got, k;
    got = 0;
    k = 0;
    build(12'h600, 32'h0, 32'h0, 32'h700, 32'h8000_0004);
    put_w(12'h700, 32'h4433_2211);
    reg_wr(`REG_TX_PTR, 32'h600);
    reg_wr(`REG_CTRL, 32'h3);
    while (got < 4) begin
      @(negedge pclk);
      v = tx_valid && tx_ready;
      dd = tx_data;
      ll = tx_last;
      @(posedge pclk);
      if (v === 1'b1) begin
        chk(dd, 8'h11 * 8'(got + 1));
        chk({31'h0, ll}, {31'h0, got == 3});
        got++;
      end
      tx_ready <= ~tx_ready;
      k++;
      if (k > 300) timeout_hit();
    end
    wait_idle();
    chk(get_w(12'h604), 32'h0000_8000);
    reg_chk(`REG_STATUS, 32'h6, 1'b0);
    $display("test tx done");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    rx_data = 0; rx_valid = 0; rx_last = 0; rx_error = 0; tx_ready = 0; slow = 0;
    n_mismatch = 0;
    samples_checked = 0;
    for (int i = 0; i < 4096; i++) host.bytes_m[i] = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_rx_chain();
    test_rx_stop();
    test_overflow();
    test_tx();
    tally_and_finish();
  end
  initial begin
    #6_000_000;
    timeout_hit();
  end
endmodule
